// ---- rtl/card_ctl.sv ----
// Control and status line handling for a 16-bit card socket
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Memory card holds ready low while busy
// [RQ2] Ready meaning only in memory-only mode
// [RQ3] I/O card pulls interrupt low for service
// [RQ4] Attribute select high on common accesses
// [RQ5] Attribute select pairs with matching strobes
// [RQ6] DMA acknowledge on attribute select line
// [RQ7] Drive card reset for hard reset
// [RQ8] Voltage from sense plus detect lines
// [RQ9] Wait stretches the cycle in progress
// [RQ10] Write strobe latches memory write data
// [RQ11] Write strobe is DMA read terminal count
// [RQ12] Memory card shows protect switch state
// [RQ13] I/O mode reads protect as wide port
// [RQ14] Card flags wide port for own addresses
// [RQ15] DMA card requests via protect line
// [RQ16] Output enable low for memory reads
// [RQ17] Output enable is DMA write terminal count
// [RQ18] Synchronise every card input first; card_present reaches the voltage decode unsynchronised
module card_ctl
    import card_ctl_pkg::*;
#(
    parameter logic [3:0] setup_len = setup_cycles,
    parameter logic [3:0] strobe_len = strobe_cycles,
    parameter logic [3:0] hold_len = hold_cycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Socket configuration
    input card_ctl_pkg::socket_mode_e mode,
    input wire logic card_present,
    input wire logic card_reset_req,
    // Host cycle request
    input wire logic req_valid,
    input card_ctl_pkg::cycle_op_e req_op,
    input wire logic req_last,
    output logic req_ready,
    output logic cycle_done,
    // Card pins in
    input card_ctl_pkg::card_inputs_s card_in,
    // Card pins out
    output card_ctl_pkg::card_strobes_s card_out,
    output logic card_reset,
    // Status toward host
    output logic card_ready,
    output logic card_interrupt_request,
    output logic write_protect,
    output logic wide_io_port_indication,
    output logic dma_request,
    output card_ctl_pkg::card_voltage_e voltage
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    card_inputs_s in_sync; // Synchronised card inputs
    cycle_state_e state; // Sequencer state
    cycle_state_e next_state;
    logic [3:0] count; // Phase counter
    cycle_op_e op; // Latched cycle kind
    logic last; // Latched terminal count request
    logic [3:0] reset_count; // Card reset stretch
    card_strobes_s next_out;
    logic waiting; // Card holds the cycle
    cycle_op_e cur_op; // Cycle kind seen by the select decode

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    card_input_sync #(
        .width(input_width)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .raw(card_in),
        .synced(in_sync) // RQ18
    );

    // Voltage decode
    card_voltage_decode u_volt (
        .clk(clk),
        .srst(srst),
        .voltage_sense_one(in_sync.voltage_sense_one),
        .voltage_sense_two(in_sync.voltage_sense_two),
        .card_present(card_present),
        .voltage(voltage)
    );

    ////////////////////////////////////////////////////////////////////
    // Shared input interpretation, depends on socket mode
    always_ff @(posedge clk) begin
        if (srst) begin
            card_ready <= 1'b0;
            card_interrupt_request <= 1'b0;
            write_protect <= 1'b0;
            wide_io_port_indication <= 1'b0;
            dma_request <= 1'b0;
        end else begin
            // Ready only counts in memory-only mode
            card_ready <= (mode == mode_memory) && in_sync.ready_irq; // RQ2 RQ1
            // Interrupt is the same pin, active low, in I/O modes
            card_interrupt_request <= (mode != mode_memory) && !in_sync.ready_irq; // RQ3
            write_protect <= (mode == mode_memory) && in_sync.protect_io16; // RQ12
            // Active low wide-port flag in I/O mode
            wide_io_port_indication <= (mode == mode_io) && !in_sync.protect_io16; // RQ13 RQ14
            dma_request <= (mode == mode_dma) && in_sync.protect_io16; // RQ15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Card reset stretch; held at least a fixed count after request drops
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_count <= reset_hold_cycles;
        end else if (card_reset_req) begin
            reset_count <= reset_hold_cycles;
        end else if (reset_count != count_zero) begin
            reset_count <= reset_count - count_one;
        end
    end

    // Registered card reset output
    always_ff @(posedge clk) begin
        if (srst) begin
            card_reset <= 1'b1;
        end else begin
            card_reset <= card_reset_req || (reset_count != count_zero); // RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wait only matters during the strobe phase
    assign waiting = (state == st_strobe) && !in_sync.wait_n; // RQ9

    // No cycles accepted while the card is held in reset
    assign req_ready = (state == st_idle) && !card_reset;

    // Latched kind is one cycle late at the take edge, so use the request there
    assign cur_op = (state == st_idle) ? req_op : op;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (req_valid && req_ready) begin
                    next_state = st_setup;
                end
            end
            st_setup: begin
                if (count == count_zero) begin
                    next_state = st_strobe;
                end
            end
            st_strobe: begin
                // Count expired and no wait: release strobes
                if (count == count_zero && !waiting) begin
                    next_state = st_hold; // RQ9
                end
            end
            st_hold: begin
                if (count == count_zero) begin
                    next_state = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter; holds at zero while the card waits
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= count_zero;
        end else if (state != next_state) begin
            case (next_state)
                st_setup: count <= setup_len - count_one;
                st_strobe: count <= strobe_len - count_one;
                st_hold: count <= hold_len - count_one;
                default: count <= count_zero;
            endcase
        end else if (count != count_zero) begin
            count <= count - count_one;
        end
    end

    // Latch the request
    always_ff @(posedge clk) begin
        if (srst) begin
            op <= op_common_read;
            last <= 1'b0;
        end else if (req_valid && req_ready) begin
            op <= req_op;
            last <= req_last;
        end
    end

    // Completion pulse in the cycle after the final hold cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cycle_done <= 1'b0;
        end else begin
            cycle_done <= (state == st_hold) && (count == count_zero);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strobe decode; attribute select spans setup through hold
    always_comb begin
        next_out = strobes_idle;
        if (next_state != st_idle) begin
            case (cur_op)
                op_common_read, op_common_write: next_out.attr_select_n = 1'b1; // RQ4
                default: next_out.attr_select_n = 1'b0; // RQ5 RQ6
            endcase
        end
        if (next_state == st_strobe) begin
            case (op)
                op_common_read, op_attr_read: next_out.output_enable_n = 1'b0; // RQ16 RQ5
                op_common_write, op_attr_write: next_out.write_enable_n = 1'b0; // RQ10 RQ5
                op_io_read: next_out.io_read_strobe_n = 1'b0; // RQ5
                op_io_write: next_out.io_write_strobe_n = 1'b0; // RQ5
                op_dma_read: begin
                    // Memory-to-card transfer strobed by the write-side line
                    next_out.io_write_strobe_n = 1'b0; // RQ6
                    next_out.write_enable_n = !last; // RQ11
                end
                op_dma_write: begin
                    next_out.io_read_strobe_n = 1'b0; // RQ6
                    next_out.output_enable_n = !last; // RQ17
                end
                default: next_out = strobes_idle;
            endcase
        end
    end

    // Registered strobe pins, glitch free
    always_ff @(posedge clk) begin
        if (srst) begin
            card_out <= strobes_idle;
        end else begin
            card_out <= next_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_common_attr_high;
        @(posedge clk) disable iff (srst)
        (!card_out.output_enable_n && (op == op_common_read)) |-> card_out.attr_select_n;
    endproperty
    a_common_attr_high: assert property (p_common_attr_high) else $error("attr low on common"); // RQ4

    property p_ready_mode;
        @(posedge clk) disable iff (srst)
        (mode != mode_memory) && $stable(mode) |=> !card_ready;
    endproperty
    a_ready_mode: assert property (p_ready_mode) else $error("ready outside memory mode"); // RQ2

    property p_io_attr;
        @(posedge clk) disable iff (srst)
        (!card_out.io_read_strobe_n || !card_out.io_write_strobe_n) |-> !card_out.attr_select_n;
    endproperty
    a_io_attr: assert property (p_io_attr) else $error("io strobe without attr select"); // RQ5

    property p_dma_read_pair;
        @(posedge clk) disable iff (srst)
        (!card_out.io_write_strobe_n && op == op_dma_read) |-> !card_out.attr_select_n
            && card_out.io_read_strobe_n;
    endproperty
    a_dma_read_pair: assert property (p_dma_read_pair) else $error("dma read pairing"); // RQ6

    property p_reset_hold;
        @(posedge clk) disable iff (srst)
        $fell(card_reset_req) |=> card_reset [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("card reset short"); // RQ7

    property p_wait_holds;
        @(posedge clk) disable iff (srst)
        waiting |=> (state == st_strobe);
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("cycle ended during wait"); // RQ9

    property p_tc_read;
        @(posedge clk) disable iff (srst)
        (state == st_strobe && op == op_dma_read && last) |-> !card_out.write_enable_n;
    endproperty
    a_tc_read: assert property (p_tc_read) else $error("no read terminal count"); // RQ11

    property p_tc_write;
        @(posedge clk) disable iff (srst)
        (state == st_strobe && op == op_dma_write && last) |-> !card_out.output_enable_n;
    endproperty
    a_tc_write: assert property (p_tc_write) else $error("no write terminal count"); // RQ17

    property p_cycle_bound;
        @(posedge clk) disable iff (srst)
        (req_valid && req_ready && in_sync.wait_n) ##1 in_sync.wait_n [*8] |-> ##[0:8] cycle_done;
    endproperty
    a_cycle_bound: assert property (p_cycle_bound) else $error("cycle overran"); // RQ9

    c_mem_write: cover property (@(posedge clk) disable iff (srst)
        !card_out.write_enable_n && op == op_common_write);
    c_waited: cover property (@(posedge clk) disable iff (srst) waiting ##3 !waiting);
    c_dma_tc: cover property (@(posedge clk) disable iff (srst)
        state == st_strobe && op == op_dma_write && last);

endmodule

// ---- rtl/card_ctl_pkg.sv ----
// Shared types and constants for the 16-bit card control-line block
package card_ctl_pkg;

    // Socket interface modes
    typedef enum logic [1:0] {
        mode_memory = 2'b00, // Memory-only interface
        mode_io = 2'b01,     // Memory and I/O interface
        mode_dma = 2'b11     // I/O card with DMA support
    } socket_mode_e;

    // Cycle kinds requested by the host side
    typedef enum logic [2:0] {
        op_common_read = 3'b000,
        op_common_write = 3'b001,
        op_attr_read = 3'b011,
        op_attr_write = 3'b010,
        op_io_read = 3'b110,
        op_io_write = 3'b111,
        op_dma_read = 3'b101,
        op_dma_write = 3'b100
    } cycle_op_e;

    // Cycle sequencer states, Gray along setup, strobe, hold
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_setup = 2'b01,
        st_strobe = 2'b11,
        st_hold = 2'b10
    } cycle_state_e;

    // Card-facing strobes, all active low on the pins
    typedef struct packed {
        logic attr_select_n;     // Attribute select / dma_acknowledge
        logic output_enable_n;   // Read enable / DMA write terminal count
        logic write_enable_n;    // Write strobe / DMA read terminal count
        logic io_read_strobe_n;
        logic io_write_strobe_n;
    } card_strobes_s;

    // Synchronised card inputs
    typedef struct packed {
        logic ready_irq;         // Ready, or card_interrupt_request when low
        logic wait_n;
        logic protect_io16;      // Write protect / wide_io_port_indication / DMA request
        logic voltage_sense_one;
        logic voltage_sense_two;
    } card_inputs_s;

    // Card voltage classes
    typedef enum logic [1:0] {
        volt_5v = 2'b00,
        volt_3v3 = 2'b01,
        volt_xv = 2'b10,
        volt_none = 2'b11
    } card_voltage_e;

    localparam int sync_stages = 2;
    localparam int input_width = 5;
    localparam logic [3:0] setup_cycles = 4'h0002;
    localparam logic [3:0] strobe_cycles = 4'h0006;
    localparam logic [3:0] hold_cycles = 4'h0002;
    localparam logic [3:0] reset_hold_cycles = 4'h000a;
    localparam logic [3:0] count_zero = 4'h0000;
    localparam logic [3:0] count_one = 4'h0001;
    localparam card_strobes_s strobes_idle = 5'h001f;

endpackage

// ---- rtl/card_input_sync.sv ----
// Two-flop synchroniser bank for card-driven inputs
`timescale 1ns/10ps
module card_input_sync #(
    parameter int width = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw and synchronised lines
    input wire logic [width-1:0] raw,
    output logic [width-1:0] synced
);
    import card_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage, never logic
    logic [width-1:0] stage_one;

    // Per-bit two-flop chain; reset level high matches idle pulled lines
    for (genvar i = 0; i < width; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (srst) begin
                stage_one[i] <= 1'b1;
                synced[i] <= 1'b1;
            end else begin
                stage_one[i] <= raw[i];
                synced[i] <= stage_one[i];
            end
        end
    end

endmodule

// ---- rtl/card_voltage_decode.sv ----
// Voltage class decode from sense and detect lines
`timescale 1ns/10ps
module card_voltage_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Synchronised sense lines; detect taken straight from the card_present port
    input wire logic voltage_sense_one,
    input wire logic voltage_sense_two,
    input wire logic card_present,
    // Registered result
    output card_ctl_pkg::card_voltage_e voltage
);
    import card_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Decoded value before the register
    card_voltage_e next_voltage;

    // Sense lines only mean something with a card seated
    always_comb begin
        if (!card_present) begin
            next_voltage = volt_none;
        end else begin
            case ({voltage_sense_two, voltage_sense_one})
                2'b11: next_voltage = volt_5v;
                2'b10: next_voltage = volt_3v3;
                2'b01: next_voltage = volt_xv;
                default: next_voltage = volt_3v3;
            endcase
        end
    end

    // Registered output
    always_ff @(posedge clk) begin
        if (srst) begin
            voltage <= volt_none;
        end else begin
            voltage <= next_voltage; // RQ8
        end
    end

endmodule

// ---- verification/card_ctl_tb_top.sv ----
// Self-checking bench for the card control-line block
`timescale 1ns/10ps
module card_ctl_tb_top;
    import card_ctl_pkg::*;

    // Edges from take to the done pulse, no wait: setup, strobe and hold phases
    localparam int cyc_len = int'(setup_cycles) + int'(strobe_cycles) + int'(hold_cycles);

    logic clk;
    logic srst;
    socket_mode_e mode;
    logic card_present;
    logic card_reset_req;
    logic req_valid;
    cycle_op_e req_op;
    logic req_last;
    logic req_ready;
    logic cycle_done;
    card_inputs_s card_in;
    card_strobes_s card_out;
    logic card_reset;
    logic card_ready;
    logic card_interrupt_request;
    logic write_protect;
    logic wide_io_port_indication;
    logic dma_request;
    card_voltage_e voltage;
    logic card_busy; // Model knobs
    logic want_irq;
    logic switch_protect;
    logic port_wide;
    logic dma_want;
    logic [3:0] wait_len;
    logic [1:0] sense;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    card_ctl card_ctl_inst (.clk(clk), .srst(srst), .mode(mode), .card_present(card_present),
        .card_reset_req(card_reset_req), .req_valid(req_valid), .req_op(req_op),
        .req_last(req_last), .req_ready(req_ready), .cycle_done(cycle_done),
        .card_in(card_in), .card_out(card_out), .card_reset(card_reset),
        .card_ready(card_ready), .card_interrupt_request(card_interrupt_request),
        .write_protect(write_protect), .wide_io_port_indication(wide_io_port_indication),
        .dma_request(dma_request), .voltage(voltage));

    card_model card_model_inst (.clk(clk), .mode(mode), .strobes(card_out),
        .card_busy(card_busy), .want_irq(want_irq), .switch_protect(switch_protect),
        .port_wide(port_wide), .dma_want(dma_want), .wait_len(wait_len), .sense(sense),
        .card_in(card_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [4:0] got, input logic [4:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_range(input int v, input int lo, input int hi, input string msg);
        tests_run++;
        if (v < lo || v > hi) begin
            fails++;
            $display("Error at %0t: %s count %0d outside %0d..%0d", $time, msg, v, lo, hi);
        end
    endtask

    // One host cycle; returns edges from take to done and checks the strobes seen low
    task automatic run_cycle(input socket_mode_e m, input cycle_op_e op, input logic last,
        input logic [4:0] exp_low, output int len);
        logic [4:0] seen;
        int k;
        seen = 5'h00;
        k = 0;
        len = 0;
        mode = m;
        while (req_ready !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        req_valid = 1'b1;
        req_op = op;
        req_last = last;
        @(negedge clk);
        req_valid = 1'b0;
        while (cycle_done !== 1'b1 && len < 40) begin
            @(negedge clk);
            len++;
            seen = seen | ~card_out;
        end
        check(seen, exp_low, "strobes used");
        check(card_out, strobes_idle, "strobes idle at done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset stretch and host-requested card reset
    task automatic t_reset();
        srst = 1'b1;
        repeat (5) @(negedge clk);
        check(card_out, strobes_idle, "idle strobes in reset");
        check(5'(card_reset), 5'h01, "card reset in reset");
        check(5'(req_ready), 5'h00, "ready in reset");
        srst = 1'b0;
        n = 0;
        while (card_reset === 1'b1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        check_range(n, int'(reset_hold_cycles) - 1, int'(reset_hold_cycles) + 2, "stretch");
        card_reset_req = 1'b1;
        repeat (2) @(negedge clk);
        check(5'(card_reset), 5'h01, "requested card reset");
        check(5'(req_ready), 5'h00, "ready under card reset");
        card_reset_req = 1'b0;
    endtask

    // Every cycle kind, back to back; mask bits attr, oe, we, io_read_strobe, io_write_strobe
    task automatic t_strobes();
        run_cycle(mode_memory, op_common_read, 1'b0, 5'h08, n);
        check(5'(n), 5'(cyc_len), "cycle length");
        run_cycle(mode_memory, op_common_write, 1'b0, 5'h04, n);
        run_cycle(mode_memory, op_attr_read, 1'b0, 5'h18, n);
        run_cycle(mode_memory, op_attr_write, 1'b0, 5'h14, n);
        run_cycle(mode_io, op_io_read, 1'b0, 5'h12, n);
        run_cycle(mode_io, op_io_write, 1'b0, 5'h11, n);
        run_cycle(mode_dma, op_dma_read, 1'b0, 5'h11, n);
        run_cycle(mode_dma, op_dma_read, 1'b1, 5'h15, n);
        run_cycle(mode_dma, op_dma_write, 1'b0, 5'h12, n);
        run_cycle(mode_dma, op_dma_write, 1'b1, 5'h1a, n);
        check(5'(n), 5'(cyc_len), "cycle length");
    endtask

    // Card holds wait through the strobe; the cycle must stretch
    task automatic t_wait();
        wait_len = 4'h000c;
        run_cycle(mode_io, op_io_read, 1'b0, 5'h12, n);
        check_range(n, cyc_len + 1, cyc_len + 16, "stretched cycle");
        wait_len = 4'h0000;
    endtask

    // Shared status pins read by mode
    task automatic t_status();
        mode = mode_memory;
        card_busy = 1'b1;
        want_irq = 1'b1;
        switch_protect = 1'b1;
        repeat (5) @(negedge clk);
        check(5'(card_ready), 5'h00, "busy card");
        check(5'(card_interrupt_request), 5'h00, "irq in memory mode");
        check(5'(write_protect), 5'h01, "protected");
        card_busy = 1'b0;
        switch_protect = 1'b0;
        repeat (5) @(negedge clk);
        check(5'(card_ready), 5'h01, "ready card");
        check(5'(write_protect), 5'h00, "unprotected");
        mode = mode_io;
        port_wide = 1'b1;
        repeat (5) @(negedge clk);
        check(5'(card_ready), 5'h00, "ready in io mode");
        check(5'(card_interrupt_request), 5'h01, "irq asserted");
        check(5'(wide_io_port_indication), 5'h01, "wide port");
        want_irq = 1'b0;
        port_wide = 1'b0;
        repeat (5) @(negedge clk);
        check(5'(card_ready), 5'h00, "ready pin high in io mode");
        check(5'(write_protect), 5'h00, "protect in io mode");
        check(5'(card_interrupt_request), 5'h00, "irq released");
        check(5'(wide_io_port_indication), 5'h00, "narrow port");
        mode = mode_dma;
        dma_want = 1'b1;
        repeat (5) @(negedge clk);
        check(5'(dma_request), 5'h01, "dma request");
        dma_want = 1'b0;
        repeat (5) @(negedge clk);
        check(5'(dma_request), 5'h00, "dma request released");
    endtask

    // Voltage class from sense pair and detect
    task automatic t_voltage();
        card_voltage_e vexp [4];
        vexp = '{volt_3v3, volt_xv, volt_3v3, volt_5v};
        card_present = 1'b0;
        repeat (6) @(negedge clk);
        check(5'(voltage), 5'(volt_none), "no card");
        card_present = 1'b1;
        for (int s = 0; s < 4; s++) begin
            sense = 2'(s);
            repeat (6) @(negedge clk);
            check(5'(voltage), 5'(vexp[s]), "voltage class");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1;
        mode = mode_memory;
        card_present = 1'b1;
        card_reset_req = 1'b0;
        req_valid = 1'b0;
        req_op = op_common_read;
        req_last = 1'b0;
        card_busy = 1'b0;
        want_irq = 1'b0;
        switch_protect = 1'b0;
        port_wide = 1'b0;
        dma_want = 1'b0;
        wait_len = 4'h0000;
        sense = 2'b11;
        t_reset();
        t_strobes();
        t_wait();
        t_status();
        t_voltage();
        results();
    end
endmodule

// ---- verification/card_model.sv ----
// Behavioural 16-bit card that answers the socket's strobes
`timescale 1ns/10ps
module card_model
    import card_ctl_pkg::*;
(
    // Clock
    input wire logic clk,
    // Socket side
    input card_ctl_pkg::socket_mode_e mode,
    input card_ctl_pkg::card_strobes_s strobes,
    // Card behaviour chosen by the bench
    input wire logic card_busy,
    input wire logic want_irq,
    input wire logic switch_protect,
    input wire logic port_wide,
    input wire logic dma_want,
    input wire logic [3:0] wait_len,
    input wire logic [1:0] sense,
    // Card pins
    output card_ctl_pkg::card_inputs_s card_in
);
    logic [3:0] wait_cnt = 4'h0000; // Stretch cycles still to give
    logic was_active = 1'b0; // A strobe was low last cycle
    logic active; // Any data strobe low now

    // Data strobes only; the attribute select alone is no access
    assign active = ~&strobes[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Stretch starts on the first strobe cycle of each access
    always_ff @(posedge clk) begin
        was_active <= active;
        if (active && !was_active) begin
            wait_cnt <= wait_len;
        end else if (wait_cnt != 4'h0000) begin
            wait_cnt <= wait_cnt - 4'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels; wait has a pull-up, so released means high
    always_comb begin
        card_in.wait_n = (wait_cnt == 4'h0000);
        card_in.voltage_sense_one = sense[0];
        card_in.voltage_sense_two = sense[1];
        if (mode == mode_memory) begin
            card_in.ready_irq = !card_busy;
            card_in.protect_io16 = switch_protect;
        end else begin
            card_in.ready_irq = !want_irq;
            if (mode == mode_io) begin
                card_in.protect_io16 = !port_wide;
            end else begin
                card_in.protect_io16 = dma_want;
            end
        end
    end
endmodule
